// ===== inc/eisf_pkg.sv
// Constants for the external request sense and pending flag block
// What this block does
// - Sense 00: request while pin is low
// - Sense 01: request on each falling edge
// - Sense 10: request on each rising edge
// - Sense 11: request on both edges
// - Low sense fields 7:6,3:2,1:0, reset zero
// - Pending flags at bits 5,4,3,1,0, reset zero
// - Selected sense condition sets the pending flag
// - Clear needs read of one, then write zero
// - Level mode: exception clears flag if pin high
// - Edge modes: exception handling clears the flag
// - Full variant only: transfer start with select zero clears flag
// - Writing one to a flag changes nothing
// - Request reaches CPU only when enabled
`default_nettype none

package eisf_pkg;

	// Register bus geometry
	localparam int EISF_ADDR_W = 4;
	localparam int EISF_DATA_W = 8;
	localparam int EISF_NUM_IN = 6;

	// Register offsets
	localparam logic [3:0] EISF_OFS_SENSE_HI = 4'h0;
	localparam logic [3:0] EISF_OFS_SENSE_LO = 4'h1;
	localparam logic [3:0] EISF_OFS_ENABLE = 4'h2;
	localparam logic [3:0] EISF_OFS_STATUS = 4'h3;

	// Reset values
	localparam logic [7:0] EISF_RST_SENSE = 8'h00;
	localparam logic [7:0] EISF_RST_ENABLE = 8'h00;
	localparam logic [7:0] EISF_RST_STATUS = 8'h00;
	// Pins idle high, so no false falling edge after reset
	localparam logic [5:0] EISF_RST_PIN = 6'h3F;

	// Sense field positions (low bit of each two-bit field)
	localparam int EISF_POS_IN0 = 0;
	localparam int EISF_POS_IN1 = 2;
	localparam int EISF_POS_IN3 = 6;
	localparam int EISF_POS_IN4 = 0;
	localparam int EISF_POS_IN5 = 2;

	// Writable bit masks
	localparam logic [7:0] EISF_MASK_SENSE_LO = 8'hCF;
	localparam logic [7:0] EISF_MASK_SENSE_HI = 8'h0F;
	// Inputs present on the full variant
	localparam logic [5:0] EISF_IN_FULL = 6'h3B;
	// Input 5 absent on the reduced variant
	localparam logic [5:0] EISF_IN_REDUCED = 6'h1B;

	// Sense encodings
	localparam logic [1:0] EISF_SENSE_LOW = 2'h0;
	localparam logic [1:0] EISF_SENSE_FALL = 2'h1;
	localparam logic [1:0] EISF_SENSE_RISE = 2'h2;
	localparam logic [1:0] EISF_SENSE_BOTH = 2'h3;

endpackage : eisf_pkg

`default_nettype wire

// ===== rtl/eisf_top.sv
// External request sense selection, pending flags and request gating
`default_nettype none

module eisf_top
	import eisf_pkg::*;
#(
	// One selects the full variant, zero the reduced one
	parameter int FULL_VARIANT = 1
) (
	// System clock
	input wire logic clk_sys,
	// Asynchronous reset, active high
	input wire logic rst,
	// Request pins, active low, bit n is input n
	input wire logic [5:0] ext_request_pin,
	// Exception handling taken for input n, pulse
	input wire logic [5:0] exc_ack,
	// Transfer controller started by input n, pulse
	input wire logic [5:0] dtc_start,
	// Transfer controller interrupt select per input
	input wire logic [5:0] xfer_int_select,
	// Register address
	input wire logic [EISF_ADDR_W-1:0] reg_addr,
	// Register write data
	input wire logic [EISF_DATA_W-1:0] reg_wdata,
	// Write strobe
	input wire logic reg_wr,
	// Read strobe
	input wire logic reg_rd,
	// Read data, valid the cycle after the strobe
	output logic [EISF_DATA_W-1:0] reg_rdata,
	// Gated request per input toward the CPU
	output logic [5:0] irq_request
);

	// Parameter check
	generate
		if (FULL_VARIANT != 0 && FULL_VARIANT != 1) begin : g_bad_variant
			$error("FULL_VARIANT must be 0 or 1");
		end
	endgenerate

	// Inputs that exist on this variant
	localparam logic [5:0] IN_VALID = (FULL_VARIANT == 1) ? EISF_IN_FULL : EISF_IN_REDUCED;
	// Transfer clear exists on the full variant only
	localparam logic DTC_CLEAR_ON = (FULL_VARIANT == 1);

	// Picks the two-bit sense field of input n
	function automatic logic [1:0] sense_of(
		input int n,
		input logic [7:0] lo,
		input logic [7:0] hi
	);
		logic [1:0] f;
		f = 2'h0;
		case (n)
			0: f = lo[EISF_POS_IN0 +: 2];
			1: f = lo[EISF_POS_IN1 +: 2];
			3: f = lo[EISF_POS_IN3 +: 2];
			4: f = hi[EISF_POS_IN4 +: 2];
			5: f = hi[EISF_POS_IN5 +: 2];
			default: f = 2'h0;
		endcase
		return f;
	endfunction : sense_of

	// Pin synchroniser stages and previous sample
	logic [5:0] sync1_reg;
	logic [5:0] sync2_reg;
	logic [5:0] prev_reg;
	logic [5:0] sync1_next;
	logic [5:0] sync2_next;
	logic [5:0] prev_next;

	// Software registers
	logic [7:0] sense_hi_reg;
	logic [7:0] sense_hi_next;
	// Sense fields of inputs 3, 1 and 0
	logic [7:0] sense_select_low_reg;
	logic [7:0] sense_select_low_next;
	logic [7:0] request_enable_reg;
	logic [7:0] request_enable_next;

	// Pending flags and their clear arming
	logic [5:0] pending_reg;
	logic [5:0] pending_next;
	logic [5:0] armed_reg;
	logic [5:0] armed_next;

	// Output registers
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [5:0] irq_reg;
	logic [5:0] irq_next;

	// Per-input events
	logic [5:0] set_evt;
	logic [5:0] hw_clr;
	logic [5:0] sw_clr;

	// Address hits
	logic wr_status;
	logic rd_status;

	// Decode of status accesses
	always_comb begin
		wr_status = reg_wr && (reg_addr == EISF_OFS_STATUS);
		rd_status = reg_rd && (reg_addr == EISF_OFS_STATUS);
	end

	// Synchroniser next values; first stage feeds only the second
	always_comb begin
		sync1_next = ext_request_pin;
		sync2_next = sync1_reg;
		// Previous sample for edge compare
		prev_next = sync2_reg;
	end

	// Synchroniser registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync1_reg <= EISF_RST_PIN;
			sync2_reg <= EISF_RST_PIN;
			prev_reg <= EISF_RST_PIN;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			prev_reg <= prev_next;
		end
	end

	// Software register writes
	always_comb begin
		sense_hi_next = sense_hi_reg;
		sense_select_low_next = sense_select_low_reg;
		request_enable_next = request_enable_reg;
		if (reg_wr) begin
			case (reg_addr)
				EISF_OFS_SENSE_HI: begin
					// Input 5 field absent on reduced variant
					sense_hi_next = reg_wdata & EISF_MASK_SENSE_HI &
						(IN_VALID[5] ? 8'hFF : 8'hF3);
				end
				EISF_OFS_SENSE_LO: begin
					// Reserved bits 5:4 are not stored
					sense_select_low_next = reg_wdata & EISF_MASK_SENSE_LO;
				end
				EISF_OFS_ENABLE: begin
					request_enable_next = reg_wdata & {2'h0, IN_VALID};
				end
				default: begin
					// Status and unmapped handled elsewhere
				end
			endcase
		end
	end

	// Software registers storage
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sense_hi_reg <= EISF_RST_SENSE;
			sense_select_low_reg <= EISF_RST_SENSE;
			request_enable_reg <= EISF_RST_ENABLE;
		end else begin
			sense_hi_reg <= sense_hi_next;
			sense_select_low_reg <= sense_select_low_next;
			request_enable_reg <= request_enable_next;
		end
	end

	// Per-input detection and clear conditions
	genvar gi;
	generate
		for (gi = 0; gi < EISF_NUM_IN; gi++) begin : g_in
			logic [1:0] mode;
			logic fall;
			logic rise;
			// Mode and edge terms
			always_comb begin
				mode = sense_of(gi, sense_select_low_reg, sense_hi_reg);
				fall = prev_reg[gi] && !sync2_reg[gi];
				rise = !prev_reg[gi] && sync2_reg[gi];
			end
			// Set and clear terms for this input
			always_comb begin
				set_evt[gi] = 1'b0;
				hw_clr[gi] = 1'b0;
				case (mode)
					EISF_SENSE_LOW: begin
						// Level: flag set while the pin is low
						set_evt[gi] = !sync2_reg[gi];
						hw_clr[gi] = exc_ack[gi] && sync2_reg[gi];
					end
					EISF_SENSE_FALL: begin
						set_evt[gi] = fall;
						hw_clr[gi] = exc_ack[gi];
					end
					EISF_SENSE_RISE: begin
						set_evt[gi] = rise;
						hw_clr[gi] = exc_ack[gi];
					end
					EISF_SENSE_BOTH: begin
						set_evt[gi] = fall || rise;
						hw_clr[gi] = exc_ack[gi];
					end
					default: begin
						set_evt[gi] = 1'b0;
						hw_clr[gi] = 1'b0;
					end
				endcase
				// Transfer start without interrupt select
				if (DTC_CLEAR_ON && dtc_start[gi] && !xfer_int_select[gi]) begin
					hw_clr[gi] = 1'b1;
				end
				// Missing inputs never set
				if (!IN_VALID[gi]) begin
					set_evt[gi] = 1'b0;
				end
			end
			// Written zero clears only after a read of one
			always_comb begin
				sw_clr[gi] = wr_status && !reg_wdata[gi] && armed_reg[gi];
			end
		end
	endgenerate

	// Flag update; a set in the clear cycle wins
	always_comb begin
		pending_next = set_evt | (pending_reg & ~(hw_clr | sw_clr));
		// Arm on a read that returned one; any status write disarms
		armed_next = pending_next & {6{!wr_status}} &
			(armed_reg | ({6{rd_status}} & pending_reg));
	end

	// Flag storage
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pending_reg <= EISF_RST_STATUS[5:0];
			armed_reg <= 6'h00;
		end else begin
			pending_reg <= pending_next;
			armed_reg <= armed_next;
		end
	end

	// Read data and gated requests
	always_comb begin
		rdata_next = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				EISF_OFS_SENSE_HI: rdata_next = sense_hi_reg;
				EISF_OFS_SENSE_LO: rdata_next = sense_select_low_reg;
				EISF_OFS_ENABLE: rdata_next = request_enable_reg;
				// Reserved status bits read zero
				EISF_OFS_STATUS: rdata_next = {2'h0, pending_reg & IN_VALID};
				default: rdata_next = 8'h00;
			endcase
		end
		// Enable gates the flag onto the request line
		irq_next = pending_reg & request_enable_reg[5:0] & IN_VALID;
	end

	// Output registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_reg <= 8'h00;
			irq_reg <= 6'h00;
		end else begin
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
		end
	end

	// Outputs straight from flops
	assign reg_rdata = rdata_reg;
	assign irq_request = irq_reg;

endmodule : eisf_top

`default_nettype wire

// ===== test/eisf_pin_model.sv
// Far-side model of the devices on the request pins
`default_nettype none
module eisf_pin_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [5:0] drive_low,
	output logic [5:0] ext_request_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pull-ups hold released pins high
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ext_request_pin <= 6'h3F;
		end else begin
			ext_request_pin <= ~drive_low;
		end
	end
endmodule : eisf_pin_model
`default_nettype wire

// ===== test/eisf_top_properties.sv
// Port checker for the sense and pending flag block
`default_nettype none
module eisf_checker
	import eisf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [5:0] ext_request_pin,
	input wire logic [5:0] exc_ack,
	input wire logic [5:0] dtc_start,
	input wire logic [5:0] xfer_int_select,
	input wire logic [EISF_ADDR_W-1:0] reg_addr,
	input wire logic [EISF_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [EISF_DATA_W-1:0] reg_rdata,
	input wire logic [5:0] irq_request
);
	timeunit 1ns;
	timeprecision 1ps;
	// Enable mirror, rebuilt from bus writes only
	logic [5:0] en_reg;
	logic [5:0] en_next;
	// Marks the slot right after a status read strobe
	logic st_rd_reg;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_rd_reg <= 1'b0;
		end else begin
			st_rd_reg <= reg_rd && (reg_addr == EISF_OFS_STATUS);
		end
	end
	always_comb begin
		en_next = en_reg;
		if (reg_wr && reg_addr == EISF_OFS_ENABLE) begin
			en_next = reg_wdata[5:0];
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			en_reg <= 6'h00;
		end else begin
			en_reg <= en_next;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside slot");
	a_unmapped: assert property ($past(reg_rd) && $past(reg_addr) > 4'h3 |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_lo_rsvd: assert property ($past(reg_rd) && $past(reg_addr) == EISF_OFS_SENSE_LO |-> reg_rdata[5:4] == 2'h0)
		else $error("sense reserved bits set");
	a_st_rsvd: assert property (st_rd_reg |-> reg_rdata[7:6] == 2'h0 && !reg_rdata[2])
		else $error("status reserved set");
	a_req_en: assert property ((irq_request & ~$past(en_reg)) == 6'h00) else $error("request not enabled");
	a_req_match: assert property (st_rd_reg |-> irq_request == (reg_rdata[5:0] & $past(en_reg)))
		else $error("request differs from flags");
	a_sense_rb: assert property (reg_wr && reg_addr == EISF_OFS_SENSE_LO ##1 reg_rd && reg_addr == EISF_OFS_SENSE_LO
		|=> reg_rdata == ($past(reg_wdata, 2) & EISF_MASK_SENSE_LO)) else $error("sense readback wrong");
	a_w1_keep: assert property (reg_wr && reg_addr == EISF_OFS_STATUS && reg_wdata[5:0] == 6'h3B && exc_ack == 6'h00
		&& dtc_start == 6'h00 |-> ##2 (irq_request & $past(irq_request)) == $past(irq_request))
		else $error("write of one cleared flag");
endmodule : eisf_checker
bind eisf_top eisf_checker u_eisf_checker (.clk_sys(clk_sys), .rst(rst), .ext_request_pin(ext_request_pin),
	.exc_ack(exc_ack), .dtc_start(dtc_start), .xfer_int_select(xfer_int_select), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_request(irq_request));
`default_nettype wire

// ===== test/tb_eisf_top.sv
// Self-checking bench for the sense and pending flag block
`default_nettype none
module tb_eisf_top
	import eisf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst, reg_wr, reg_rd;
	logic [5:0] drive_low, ext_request_pin, exc_ack, dtc_start, xfer_int_select, irq_request;
	logic [EISF_ADDR_W-1:0] reg_addr;
	logic [EISF_DATA_W-1:0] reg_wdata, reg_rdata;
	int mismatches, checks_done;
	eisf_top #(.FULL_VARIANT(1)) u_eisf_top (.clk_sys(clk_sys), .rst(rst), .ext_request_pin(ext_request_pin),
		.exc_ack(exc_ack), .dtc_start(dtc_start), .xfer_int_select(xfer_int_select), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_request(irq_request));
	eisf_pin_model u_eisf_pin_model (.clk_sys(clk_sys), .rst(rst), .drive_low(drive_low),
		.ext_request_pin(ext_request_pin));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data exist only in the slot after the strobe
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rdc
	// Pin change, then time for model, two sync stages and flag
	task automatic pins(input logic [5:0] lo);
		@(posedge clk_sys);
		drive_low <= lo;
		repeat (6) @(posedge clk_sys);
	endtask : pins
	task automatic ev(input logic [5:0] a, input logic [5:0] d);
		@(posedge clk_sys);
		exc_ack <= a;
		dtc_start <= d;
		@(posedge clk_sys);
		exc_ack <= 6'h00;
		dtc_start <= 6'h00;
	endtask : ev
	task automatic t_reset;
		for (int a = 0; a < 6; a++) rdc(a[3:0], 8'h00);
		$display("t_reset done");
	endtask : t_reset
	// Every sense code on inputs 3, 1 and 0 together
	task automatic t_modes;
		wr(EISF_OFS_ENABLE, 8'h09);
		for (int c = 0; c < 4; c++) begin
			@(posedge clk_sys);
			reg_wr <= 1'b1;
			reg_addr <= EISF_OFS_SENSE_LO;
			reg_wdata <= {c[1:0], 2'h0, c[1:0], c[1:0]};
			@(posedge clk_sys);
			reg_wr <= 1'b0;
			reg_rd <= 1'b1;
			@(posedge clk_sys);
			reg_rd <= 1'b0;
			#1 chk(reg_rdata, {c[1:0], 2'h0, c[1:0], c[1:0]});
			pins(6'h0B);
			rdc(EISF_OFS_STATUS, c != 2 ? 8'h0B : 8'h00);
			chk({2'h0, irq_request}, c != 2 ? 8'h09 : 8'h00);
			ev(6'h0B, 6'h00);
			rdc(EISF_OFS_STATUS, c == 0 ? 8'h0B : 8'h00);
			pins(6'h00);
			rdc(EISF_OFS_STATUS, c != 1 ? 8'h0B : 8'h00);
			ev(6'h0B, 6'h00);
			rdc(EISF_OFS_STATUS, 8'h00);
		end
		$display("t_modes done");
	endtask : t_modes
	// Clear by software needs a prior read of one
	task automatic t_sw_clear;
		wr(EISF_OFS_SENSE_LO, 8'h45);
		pins(6'h0B);
		wr(EISF_OFS_STATUS, 8'h00);
		rdc(EISF_OFS_STATUS, 8'h0B);
		wr(EISF_OFS_STATUS, 8'h3B);
		rdc(EISF_OFS_STATUS, 8'h0B);
		wr(EISF_OFS_STATUS, 8'h08);
		rdc(EISF_OFS_STATUS, 8'h08);
		wr(EISF_OFS_STATUS, 8'h00);
		rdc(EISF_OFS_STATUS, 8'h00);
		pins(6'h00);
		$display("t_sw_clear done");
	endtask : t_sw_clear
	// Transfer start clears only where interrupt select is zero
	task automatic t_dtc;
		xfer_int_select <= 6'h01;
		pins(6'h0B);
		ev(6'h00, 6'h0B);
		rdc(EISF_OFS_STATUS, 8'h01);
		pins(6'h00);
		$display("t_dtc done");
	endtask : t_dtc
	// Inputs 5 and 4 in default low-level sense; a set beats clears in the same cycle
	task automatic t_high;
		ev(6'h01, 6'h00);
		wr(EISF_OFS_ENABLE, 8'h30);
		pins(6'h30);
		rdc(EISF_OFS_STATUS, 8'h30);
		chk({2'h0, irq_request}, 8'h30);
		ev(6'h30, 6'h30);
		rdc(EISF_OFS_STATUS, 8'h30);
		pins(6'h00);
		ev(6'h30, 6'h00);
		rdc(EISF_OFS_STATUS, 8'h00);
		chk({2'h0, irq_request}, 8'h00);
		$display("t_high done");
	endtask : t_high
	// Guard against a hung run
	initial begin
		#100us;
		mismatches++;
		stop_test();
	end
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		drive_low = 6'h00;
		exc_ack = 6'h00;
		dtc_start = 6'h00;
		xfer_int_select = 6'h00;
		mismatches = 0;
		checks_done = 0;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_modes();
		t_sw_clear();
		t_dtc();
		t_high();
		stop_test();
	end
endmodule : tb_eisf_top
`default_nettype wire
